// [hrc_pkg.sv]
// constants and types for the receive port register bank
package hrc_pkg;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} hrc_req_s;
	// offsets
	localparam logic [7:0] OFS_DAT_LAST = 8'h1C;
	localparam logic [7:0] OFS_DAT_SPAN = 8'h03;
	localparam logic [7:0] OFS_ST_POP = 8'h40;
	localparam logic [7:0] OFS_ST_PEEK = 8'h44;
	localparam logic [7:0] OFS_ID = 8'h50;
	localparam logic [7:0] OFS_CTRL = 8'h54;
	localparam logic [7:0] OFS_STS = 8'h58;
	localparam logic [7:0] OFS_DROP = 8'h5C;
	localparam logic [7:0] OFS_SCR = 8'h60;
	localparam logic [7:0] OFS_CMD = 8'h64;
	// control fields
	localparam int CTRL_SRST = 0;
	localparam int CTRL_B16 = 1;
	localparam int CTRL_RXL = 8;
	localparam int CTRL_STL = 16;
	localparam int CTRL_TXL = 24;
	// status fields
	localparam int STS_OVF = 0;
	localparam int STS_UNF = 1;
	localparam int STS_LL = 2;
	localparam int STS_LH = 3;
	// reset values
	localparam logic [7:0] LIM_RST = 8'h10;
	localparam logic [31:0] SCR_RST = 32'h0000_0000;
	localparam logic [31:0] CMD_RST = 32'h0000_0000;
	// identity value is arbitrary
	localparam logic [31:0] ID_VAL = 32'h0A5C_0001;
endpackage : hrc_pkg

// [hrc_rx_port.sv]
// receive queue ports and register access attributes
`timescale 1ns/1ps
`default_nettype none
module hrc_rx_port #(
	parameter int DEPTH = 16,
	parameter int SDEPTH = 16
) (
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// register port
	input wire hrc_pkg::hrc_req_s req_in,
	output logic [31:0] rdata_out,
	// receive data from the mac
	input wire logic [31:0] rxd_data_in,
	input wire logic rxd_valid_in,
	output logic rxd_ready_out,
	// receive status from the mac
	input wire logic [31:0] rxs_data_in,
	input wire logic rxs_valid_in,
	output logic rxs_ready_out,
	// line conditions and events
	input wire logic link_ok_in,
	input wire logic err_in,
	input wire logic drop_evt_in,
	// configuration toward the rest of the chip
	output logic [7:0] tx_depth_out,
	output logic [31:0] host_cmd_out,
	output logic soft_rst_out
);
	localparam int AW = $clog2(DEPTH);
	localparam int SAW = $clog2(SDEPTH);
	logic [31:0] dmem [DEPTH];
	logic [31:0] smem [SDEPTH];
	logic [31:0] sk_r [2];
	logic [1:0] skc_r;
	logic [AW-1:0] dwp_r;
	logic [AW-1:0] drp_r;
	logic [AW:0] dcnt_r;
	logic [SAW-1:0] swp_r;
	logic [SAW-1:0] srp_r;
	logic [SAW:0] scnt_r;
	logic half_r;
	logic b16_r;
	logic srst_r;
	logic [7:0] rxl_r;
	logic [7:0] stl_r;
	logic [7:0] txl_r;
	logic [1:0] stk_r;
	logic ll_r;
	logic lh_r;
	logic [7:0] drop_r;
	logic [31:0] scr_r;
	logic [31:0] cmd_r;
	logic [31:0] rdata_r;
	// address decode
	wire [7:0] a = req_in.addr;
	wire [31:0] wd = req_in.wdata;
	wire rd = ce_in & req_in.rd;
	wire wr = ce_in & req_in.wr;
	wire hit_dat = a <= (hrc_pkg::OFS_DAT_LAST + hrc_pkg::OFS_DAT_SPAN);
	wire hit_pop = a == hrc_pkg::OFS_ST_POP;
	wire hit_peek = a == hrc_pkg::OFS_ST_PEEK;
	wire hit_id = a == hrc_pkg::OFS_ID;
	wire hit_ctrl = a == hrc_pkg::OFS_CTRL;
	wire hit_sts = a == hrc_pkg::OFS_STS;
	wire hit_drop = a == hrc_pkg::OFS_DROP;
	wire hit_scr = a == hrc_pkg::OFS_SCR;
	wire hit_cmd = a == hrc_pkg::OFS_CMD;
	wire ctrl_wr = wr & hit_ctrl;
	wire sts_wr = wr & hit_sts;
	wire sts_rd = rd & hit_sts;
	wire drop_rd = rd & hit_drop;
	// two-entry buffer between mac and data queue
	wire d_full = (int'(dcnt_r) >= int'(rxl_r)) || (int'(dcnt_r) >= DEPTH);
	wire d_empty = dcnt_r == '0;
	wire sk_in = ce_in & rxd_valid_in & rxd_ready_out;
	wire d_push = ce_in & (skc_r != 2'h0) & ~d_full;
	wire [1:0] sk_slot = skc_r - {1'b0, d_push};
	wire [1:0] skc_nxt = skc_r + {1'b0, sk_in} - {1'b0, d_push};
	assign rxd_ready_out = skc_r != 2'h2;
	// data queue pops: every read consumes, 16-bit mode on the upper half
	wire rd_dat = rd & hit_dat;
	wire d_pop = rd_dat & ~d_empty & (~b16_r | half_r);
	// status queue
	wire s_empty = scnt_r == '0;
	wire s_full = (int'(scnt_r) >= int'(stl_r)) || (int'(scnt_r) >= SDEPTH);
	assign rxs_ready_out = ~s_full;
	wire s_push = ce_in & rxs_valid_in & ~s_full;
	wire s_pop = rd & hit_pop & ~s_empty;
	wire [31:0] s_head = smem[srp_r];
	// hardware-set sticky events
	wire [1:0] stk_set = {rd_dat & d_empty, ce_in & rxs_valid_in & s_full};
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			skc_r <= 2'h0;
		else if (ce_in)
			skc_r <= srst_r ? 2'h0 : skc_nxt;
	end
	// buffer contents need no reset; count guards them
	always_ff @(posedge sys_clk_in)
	begin
		if (ce_in)
		begin
			if (d_push)
				sk_r[0] <= sk_r[1];
			if (sk_in)
				sk_r[sk_slot[0]] <= rxd_data_in;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (d_push)
			dmem[dwp_r] <= sk_r[0];
		if (s_push)
			smem[swp_r] <= rxs_data_in;
	end
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			dwp_r <= '0;
			drp_r <= '0;
			dcnt_r <= '0;
			half_r <= 1'b0;
		end
		else if (ce_in)
		begin
			dwp_r <= srst_r ? '0 : dwp_r + AW'(d_push);
			drp_r <= srst_r ? '0 : drp_r + AW'(d_pop);
			dcnt_r <= srst_r ? '0 : dcnt_r + (AW+1)'(d_push) - (AW+1)'(d_pop);
			if (srst_r)
				half_r <= 1'b0;
			else if (rd_dat & ~d_empty & b16_r)
				half_r <= ~half_r;
		end
	end
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			swp_r <= '0;
			srp_r <= '0;
			scnt_r <= '0;
		end
		else if (ce_in)
		begin
			swp_r <= srst_r ? '0 : swp_r + SAW'(s_push);
			srp_r <= srst_r ? '0 : srp_r + SAW'(s_pop);
			scnt_r <= srst_r ? '0 : scnt_r + (SAW+1)'(s_push) - (SAW+1)'(s_pop);
		end
	end
	// control: soft reset pulse is self clearing
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			srst_r <= 1'b0;
			b16_r <= 1'b0;
			rxl_r <= hrc_pkg::LIM_RST;
			stl_r <= hrc_pkg::LIM_RST;
			txl_r <= hrc_pkg::LIM_RST;
			cmd_r <= hrc_pkg::CMD_RST;
		end
		else if (ce_in)
		begin
			srst_r <= ctrl_wr & wd[hrc_pkg::CTRL_SRST] & ~srst_r;
			if (srst_r)
			begin
				b16_r <= 1'b0;
				rxl_r <= hrc_pkg::LIM_RST;
				stl_r <= hrc_pkg::LIM_RST;
				txl_r <= hrc_pkg::LIM_RST;
				cmd_r <= hrc_pkg::CMD_RST;
			end
			else
			begin
				if (ctrl_wr)
				begin
					b16_r <= wd[hrc_pkg::CTRL_B16];
					rxl_r <= wd[hrc_pkg::CTRL_RXL +: 8];
					stl_r <= wd[hrc_pkg::CTRL_STL +: 8];
					txl_r <= wd[hrc_pkg::CTRL_TXL +: 8];
				end
				if (wr & hit_cmd)
					cmd_r <= wd;
			end
		end
	end

	// write-one-clear flags; a set in the clearing cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_stk
			always_ff @(posedge sys_clk_in or negedge resetn_in)
			begin
				if (!resetn_in)
					stk_r[gi] <= 1'b0;
				else if (ce_in)
					stk_r[gi] <= ~srst_r & (stk_set[gi] | (stk_r[gi]
						& ~(sts_wr & wd[hrc_pkg::STS_OVF + gi])));
			end
		end
	endgenerate

	// latching bits, clear-on-read counter, immune scratch
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ll_r <= 1'b1;
			lh_r <= 1'b0;
			drop_r <= '0;
			scr_r <= hrc_pkg::SCR_RST;
		end
		else if (ce_in)
		begin
			ll_r <= srst_r | (sts_rd ? link_ok_in : ll_r & link_ok_in);
			lh_r <= ~srst_r & (sts_rd ? err_in : lh_r | err_in);
			if (srst_r | drop_rd)
				drop_r <= 8'(drop_evt_in);
			else
				drop_r <= drop_r + 8'(drop_evt_in);
			if (wr & hit_scr)
				scr_r <= wd;
		end
	end

	// read selection; id, queues and unmapped take no write
	wire [31:0] dw = dmem[drp_r];
	wire [15:0] dh = half_r ? dw[31:16] : dw[15:0];
	wire [31:0] dat_val = d_empty ? '0 : (b16_r ? {16'h0000, dh} : dw);
	wire [31:0] st_val = s_empty ? '0 : s_head;
	wire [31:0] sts_val = {28'h000_0000, lh_r, ll_r, stk_r};
	wire [31:0] ctrl_val = {txl_r, stl_r, rxl_r, 6'h00, b16_r, 1'b0};
	wire [31:0] rd_val =
		hit_dat ? dat_val :
		(hit_pop | hit_peek) ? st_val :
		hit_id ? hrc_pkg::ID_VAL :
		hit_ctrl ? ctrl_val :
		hit_sts ? sts_val :
		hit_drop ? {24'h00_0000, drop_r} :
		hit_scr ? scr_r : '0;

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rdata_r <= '0;
		else if (ce_in)
			rdata_r <= rd ? rd_val : '0;
	end
	assign rdata_out = rdata_r;
	assign tx_depth_out = txl_r;
	assign host_cmd_out = cmd_r;
	assign soft_rst_out = srst_r;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);
	property p_ro;
		wr & hit_dat & ~d_pop & ~d_push & ~srst_r |=> dcnt_r == $past(dcnt_r);
	endproperty
	a_ro: assert property (p_ro) else $error("queue write took effect");
	property p_wo;
		rd & hit_cmd |=> rdata_out == '0;
	endproperty
	a_wo: assert property (p_wo) else $error("write-only read nonzero");
	property p_w1c;
		sts_wr & wd[hrc_pkg::STS_OVF] & ~stk_set[0] & ~srst_r |=> ~stk_r[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared");
	property p_cor;
		drop_rd & ~drop_evt_in & ~srst_r
			|=> drop_r == '0 && rdata_out[7:0] == $past(drop_r);
	endproperty
	a_cor: assert property (p_cor) else $error("drop count not cleared");
	property p_ll;
		ce_in & ~link_ok_in & ~srst_r ##1 (~sts_rd & ~srst_r) [*2] |-> ~ll_r;
	endproperty
	a_ll: assert property (p_ll) else $error("latch low lost");
	property p_lh;
		ce_in & err_in & ~srst_r |=> lh_r;
	endproperty
	a_lh: assert property (p_lh) else $error("latch high lost");
	property p_imm;
		srst_r & ce_in & ~(wr & hit_scr) |=> scr_r == $past(scr_r);
	endproperty
	a_imm: assert property (p_imm) else $error("scratch lost on reset");
	property p_def;
		srst_r & ce_in |=> rxl_r == hrc_pkg::LIM_RST && ~b16_r && dcnt_r == '0;
	endproperty
	a_def: assert property (p_def) else $error("defaults not loaded");
	property p_pop;
		s_pop & ~s_push & ~srst_r
			|=> scnt_r == $past(scnt_r) - 1'b1 && rdata_out == $past(s_head);
	endproperty
	a_pop: assert property (p_pop) else $error("status pop wrong");
	property p_peek;
		rd & hit_peek & ~s_push & ~srst_r
			|=> scnt_r == $past(scnt_r) && srp_r == $past(srp_r);
	endproperty
	a_peek: assert property (p_peek) else $error("peek disturbed queue");
	property p_dpop;
		rd_dat & ~b16_r & ~d_empty & ~d_push & ~srst_r
			|=> dcnt_r == $past(dcnt_r) - 1'b1;
	endproperty
	a_dpop: assert property (p_dpop) else $error("data read not consumed");
	property p_half;
		rd_dat & b16_r & ~half_r & ~d_empty & ~srst_r
			|=> dcnt_r >= $past(dcnt_r) && half_r;
	endproperty
	a_half: assert property (p_half) else $error("low half popped");
endmodule : hrc_rx_port
`default_nettype wire

// [hrc_host_model.sv]
// host bus master model for the receive port register bank
`timescale 1ns/1ps
`default_nettype none
module hrc_host_model (
	// clock
	input wire logic clk_in,
	// register port
	output var hrc_pkg::hrc_req_s req_out,
	input wire logic [31:0] rdata_in
);
	initial req_out = '0;
	// reserved bits go out as the caller sets them in the write data
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		req_out.wr <= 1'b0;
	endtask : wr
	// callers never write reserved offsets, a write there is ignored
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		req_out <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		req_out.rd <= 1'b0;
		@(posedge clk_in);
		d = rdata_in;
	endtask : rd
endmodule : hrc_host_model
`default_nettype wire

// [hrc_rx_port_tb_top.sv]
// self-checking testbench for the receive port register bank
`timescale 1ns/1ps
`default_nettype none
module hrc_rx_port_tb_top;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic link_ok = 1'b1;
	logic err = 1'b0;
	logic drop = 1'b0;
	logic ce = 1'b1;
	logic [1:0] vld = 2'b00;
	logic [31:0] dat [2] = '{32'h0000_0000, 32'h0000_0000};
	wire [1:0] rdy;
	hrc_pkg::hrc_req_s req;
	logic [31:0] rdata;
	logic [7:0] tx_depth;
	logic [31:0] host_cmd;
	wire soft_rst;
	int err_total = 0;
	int checks_done = 0;
	always #12.5 sys_clk = ~sys_clk;
	hrc_host_model host (.clk_in(sys_clk), .req_out(req), .rdata_in(rdata));
	hrc_rx_port dut (
		.sys_clk_in(sys_clk), .resetn_in(resetn), .ce_in(ce),
		.req_in(req), .rdata_out(rdata),
		.rxd_data_in(dat[0]), .rxd_valid_in(vld[0]), .rxd_ready_out(rdy[0]),
		.rxs_data_in(dat[1]), .rxs_valid_in(vld[1]), .rxs_ready_out(rdy[1]),
		.link_ok_in(link_ok), .err_in(err), .drop_evt_in(drop),
		.tx_depth_out(tx_depth), .host_cmd_out(host_cmd), .soft_rst_out(soft_rst)
	);
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		host.rd(a, d);
		chk($sformatf("read %h", a), e, d);
	endtask : rc
	// mac side stream; idle data shows the inverse so stale words differ
	task automatic push(input int s, input int n, input logic [31:0] b);
		for (int i = 0; i < n; i++)
		begin
			vld[s] <= 1'b1;
			dat[s] <= b + 32'(i);
			do @(posedge sys_clk); while (rdy[s] !== 1'b1);
		end
		vld[s] <= 1'b0;
		dat[s] <= ~dat[s];
	endtask : push
	task automatic t_access;
		rc(hrc_pkg::OFS_CTRL, 32'h1010_1000);
		rc(hrc_pkg::OFS_STS, 32'h0000_0004);
		chk("tx_depth", 32'h0000_0010, {24'h00_0000, tx_depth});
		host.wr(hrc_pkg::OFS_ID, 32'h0000_0000);
		rc(hrc_pkg::OFS_ID, hrc_pkg::ID_VAL);
		host.wr(hrc_pkg::OFS_CMD, 32'hDEAD_BEEF);
		rc(hrc_pkg::OFS_CMD, 32'h0000_0000);
		chk("host_cmd", 32'hDEAD_BEEF, host_cmd);
		rc(8'h80, 32'h0000_0000);
	endtask : t_access
	task automatic t_flags;
		link_ok <= 1'b0;
		err <= 1'b1;
		@(posedge sys_clk);
		link_ok <= 1'b1;
		err <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			drop <= 1'b1;
			@(posedge sys_clk);
			drop <= 1'b0;
			@(posedge sys_clk);
		end
		rc(hrc_pkg::OFS_STS, 32'h0000_0008);
		rc(hrc_pkg::OFS_STS, 32'h0000_0004);
		rc(hrc_pkg::OFS_DROP, 32'h0000_0003);
		rc(hrc_pkg::OFS_DROP, 32'h0000_0000);
	endtask : t_flags
	task automatic t_status_q;
		push(1, 3, 32'h5000_0000);
		repeat (3) @(posedge sys_clk);
		rc(hrc_pkg::OFS_ST_PEEK, 32'h5000_0000);
		rc(hrc_pkg::OFS_ST_PEEK, 32'h5000_0000);
		rc(hrc_pkg::OFS_ST_POP, 32'h5000_0000);
		rc(hrc_pkg::OFS_ST_POP, 32'h5000_0001);
		rc(hrc_pkg::OFS_ST_PEEK, 32'h5000_0002);
		rc(hrc_pkg::OFS_ST_POP, 32'h5000_0002);
	endtask : t_status_q
	task automatic t_data_q;
		push(0, 8, 32'hD000_0000);
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 8; i++)
			rc(8'(i * 4), 32'hD000_0000 + 32'(i));
		host.wr(8'h00, 32'h1234_5678);
		rc(8'h00, 32'h0000_0000);
		rc(hrc_pkg::OFS_STS, 32'h0000_0006);
		host.wr(hrc_pkg::OFS_STS, 32'h0000_0000);
		rc(hrc_pkg::OFS_STS, 32'h0000_0006);
		host.wr(hrc_pkg::OFS_STS, 32'h0000_0002);
		rc(hrc_pkg::OFS_STS, 32'h0000_0004);
	endtask : t_data_q
	task automatic t_half;
		logic [31:0] d;
		logic [15:0] hw [4];
		hw = '{16'hC3D4, 16'hA1B2, 16'hC3D5, 16'hA1B2};
		host.wr(hrc_pkg::OFS_CTRL, 32'h1010_1002);
		push(0, 2, 32'hA1B2_C3D4);
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 4; i++)
		begin
			host.rd(8'(i * 6), d);
			chk("half", {16'h0000, hw[i]}, d);
		end
		host.wr(hrc_pkg::OFS_CTRL, 32'h1010_1000);
	endtask : t_half
	// small limit so queue and buffer fill while the host lags
	task automatic t_stall;
		host.wr(hrc_pkg::OFS_CTRL, 32'h1000_0200);
		fork
			push(0, 5, 32'hC000_0000);
		join_none
		repeat (12) @(posedge sys_clk);
		chk("rxd_ready", 32'h0000_0000, {31'h0, rdy[0]});
		for (int i = 0; i < 5; i++)
			rc(8'(28 - i * 4), 32'hC000_0000 + 32'(i));
		wait fork;
		// status limit zero: every status word overflows
		chk("rxs_ready", 32'h0000_0000, {31'h0, rdy[1]});
		vld[1] <= 1'b1;
		@(posedge sys_clk);
		vld[1] <= 1'b0;
		rc(hrc_pkg::OFS_STS, 32'h0000_0005);
		host.wr(hrc_pkg::OFS_STS, 32'h0000_0003);
		rc(hrc_pkg::OFS_STS, 32'h0000_0004);
	endtask : t_stall
	task automatic t_resets;
		host.wr(hrc_pkg::OFS_SCR, 32'hA5A5_5A5A);
		host.wr(hrc_pkg::OFS_CTRL, 32'h2020_2000);
		rc(hrc_pkg::OFS_CTRL, 32'h2020_2000);
		chk("tx_depth", 32'h0000_0020, {24'h00_0000, tx_depth});
		host.wr(hrc_pkg::OFS_CTRL, 32'h0000_0001);
		@(posedge sys_clk);
		chk("soft_rst", 32'h0000_0001, {31'h0, soft_rst});
		@(posedge sys_clk);
		chk("soft_rst", 32'h0000_0000, {31'h0, soft_rst});
		@(posedge sys_clk);
		rc(hrc_pkg::OFS_CTRL, 32'h1010_1000);
		rc(hrc_pkg::OFS_SCR, 32'hA5A5_5A5A);
		chk("tx_depth", 32'h0000_0010, {24'h00_0000, tx_depth});
		// enable low: a write must leave the scratch untouched
		ce <= 1'b0;
		host.wr(hrc_pkg::OFS_SCR, 32'h0000_0000);
		ce <= 1'b1;
		rc(hrc_pkg::OFS_SCR, 32'hA5A5_5A5A);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rc(hrc_pkg::OFS_SCR, 32'h0000_0000);
	endtask : t_resets
	initial
	begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		t_access();
		t_flags();
		t_status_q();
		t_data_q();
		t_half();
		t_stall();
		t_resets();
		give_verdict();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		give_verdict();
	end
endmodule : hrc_rx_port_tb_top
`default_nettype wire
